/* File: swcdr_regs.svh */
`ifndef SWCDR_REGS_SVH
`define SWCDR_REGS_SVH

// register addresses inside the 7-bit frame address space
`define SWCDR_ADDR_CTRL1     7'h3C
`define SWCDR_ADDR_CTRL2     7'h3D
`define SWCDR_ADDR_UPPER     7'h3E
`define SWCDR_ADDR_LOWER     7'h3F

// power-on / soft reset values
`define SWCDR_RST_CTRL1      8'h04
`define SWCDR_RST_CTRL2      8'h00
`define SWCDR_RST_UPPER      8'hA8
`define SWCDR_RST_LOWER      8'h98

// field positions in the control bytes
`define SWCDR_FILT_MSB       3
`define SWCDR_FILT_LSB       2
`define SWCDR_EN_BIT         0
`define SWCDR_SEL_MSB        1
`define SWCDR_SEL_LSB        0

// filter time constant codes and their shift amounts
`define SWCDR_FILT_8         2'h0
`define SWCDR_FILT_16        2'h1
`define SWCDR_FILT_32        2'h2
`define SWCDR_FILT_ADAPT     2'h3
`define SWCDR_SHIFT_TC8      3'h3
`define SWCDR_SHIFT_TC16     3'h4
`define SWCDR_SHIFT_TC32     3'h5

// falling edge spacing bands, in bit times
`define SWCDR_SPACE_MIN      4'h2
`define SWCDR_SPACE_32_MAX   4'h3
`define SWCDR_SPACE_16_MAX   4'h8
`define SWCDR_SPACE_MAX      4'hA

// recovery clock select codes
`define SWCDR_SEL_80M        2'h0
`define SWCDR_SEL_40M        2'h1
`define SWCDR_SEL_20M        2'h2
`define SWCDR_SEL_10M        2'h3

// serial frame layout
`define SWCDR_FRAME_BITS     5'h10
`define SWCDR_HEAD_BITS      5'h08
`define SWCDR_CNT_SAT        5'h1F
`define SWCDR_MODE_BIT       7
`define SWCDR_DATA_MSB       15
`define SWCDR_DATA_LSB       8

// fraction bits kept by the tracking filter
`define SWCDR_FRAC_W         8

`endif

/* File: swcdr_pkg.sv */
package swcdr_pkg;
	typedef logic [7:0] swcdr_byte_t;   // one register byte
	typedef logic [6:0] swcdr_addr_t;   // frame register address
	typedef logic [3:0] swcdr_nbits_t;  // falling edge spacing in bits
	typedef logic [2:0] swcdr_shift_t;  // filter shift (log2 of time constant)
endpackage : swcdr_pkg

/* File: swcdr_spi.sv */
`timescale 1ns/10ps
`include "swcdr_regs.svh"

module swcdr_spi
	import swcdr_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_rst_n,
	input  wire logic  i_cs_n,
	input  wire logic  i_sclk,
	input  wire logic  i_mosi,
	input  swcdr_byte_t i_rdata,
	output logic        o_miso,
	output swcdr_addr_t o_addr,
	output logic        o_wr,
	output swcdr_byte_t o_wdata
);

	////////////////////////////////////////////////////////////////////////////////
	logic        sclk_q,  sclk_d;   // previous clock sample
	logic        cs_q,    cs_d;     // previous select sample
	logic [4:0]  cnt_q,   cnt_d;    // bits taken this frame
	logic [15:0] frame_q, frame_d;  // lsb-first shift in
	swcdr_byte_t shift_q, shift_d;  // read data shift out
	logic        load_q,  load_d;   // load read data next cycle
	swcdr_addr_t addr_q,  addr_d;   // latched register address
	logic        wr_q,    wr_d;     // write strobe
	swcdr_byte_t wdata_q, wdata_d;  // write data
	logic        rise;              // sampled sclk rising edge

	////////////////////////////////////////////////////////////////////////////////
	// frame decode; pins are synchronous so edges come from one previous sample
	always_comb begin
		rise    = i_sclk & ~sclk_q & ~i_cs_n;
		sclk_d  = i_sclk;
		cs_d    = i_cs_n;
		cnt_d   = cnt_q;
		frame_d = frame_q;
		shift_d = shift_q;
		addr_d  = addr_q;
		wdata_d = wdata_q;
		load_d  = 1'b0;
		wr_d    = 1'b0;
		if (cs_q && !i_cs_n) begin
			// new frame: forget any leftover bits
			cnt_d   = '0;
			shift_d = '0;
		end else if (load_q) begin
			// needs sclk half period of at least two clocks
			shift_d = i_rdata;
		end else if (rise && cnt_q != `SWCDR_CNT_SAT) begin
			frame_d = {i_mosi, frame_q[15:1]};
			cnt_d   = cnt_q + 5'h01;
			// address byte done: fetch read data
			if (cnt_q == `SWCDR_HEAD_BITS - 5'h01) begin
				addr_d = frame_q[15:9];
				load_d = 1'b1;
			end
			if (cnt_q >= `SWCDR_HEAD_BITS) begin
				shift_d = {1'b0, shift_q[7:1]};
			end
		end
		if (!cs_q && i_cs_n && cnt_q == `SWCDR_FRAME_BITS && frame_q[`SWCDR_MODE_BIT]) begin
			wr_d    = 1'b1;
			wdata_d = frame_q[`SWCDR_DATA_MSB:`SWCDR_DATA_LSB];
		end
	end

	// register the frame state
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sclk_q  <= 1'b0;
			cs_q    <= 1'b1;
			cnt_q   <= '0;
			frame_q <= '0;
			shift_q <= '0;
			load_q  <= 1'b0;
			addr_q  <= '0;
			wr_q    <= 1'b0;
			wdata_q <= '0;
		end else begin
			sclk_q  <= sclk_d;
			cs_q    <= cs_d;
			cnt_q   <= cnt_d;
			frame_q <= frame_d;
			shift_q <= shift_d;
			load_q  <= load_d;
			addr_q  <= addr_d;
			wr_q    <= wr_d;
			wdata_q <= wdata_d;
		end
	end

	assign o_miso  = shift_q[0];
	assign o_addr  = addr_q;
	assign o_wr    = wr_q;
	assign o_wdata = wdata_q;

endmodule : swcdr_spi

/* File: swcdr_top.sv */
`timescale 1ns/10ps
`include "swcdr_regs.svh"
// Behaviour
// - reserved control bits always read zero
// - filter codes 00/01/10 give 8/16/32
// - code 11 adapts constant to edge spacing
// - enable bit switches recovery on and off
// - clock select picks 80/40/20/10 MHz recovery
// - measured bit time clamped at upper limit
// - measured bit time clamped at lower limit
// - control one resets to 0x04
// - clock select resets to zero
// - limits reset to 0xA8 and 0x98
// - one 16-bit frame per register access

module swcdr_top
	import swcdr_pkg::*;
#(
	parameter int CNT_W = 12
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	input  wire logic        I_SPI_CS_N,
	input  wire logic        I_SPI_SCLK,
	input  wire logic        I_SPI_MOSI,
	output logic             O_SPI_MISO,
	input  wire logic        I_RXD,
	input  wire logic [7:0]  I_NOMINAL_BIT_TIME,
	output logic             O_RECOVERY_ENABLE,
	output logic [1:0]       O_RECOVERY_CLOCK_SELECT,
	output logic [7:0]       O_BIT_TIME
);

	// counter must hold ten bits of the largest bit time, and fit the math
	if (CNT_W < 12 || CNT_W > 16) begin : g_bad_cnt
		$error("CNT_W must lie between 12 and 16");
	end

	localparam logic [7:0] RST1 = `SWCDR_RST_CTRL1;
	localparam logic [7:0] RST2 = `SWCDR_RST_CTRL2;
	localparam int         FW   = `SWCDR_FRAC_W;

	////////////////////////////////////////////////////////////////////////////////
	// clamp a value into the programmed window; upper checked first
	function automatic swcdr_byte_t clamp8(input logic [15:0] v, input swcdr_byte_t lo,
		input swcdr_byte_t hi);
		if (v > {8'h00, hi})
			clamp8 = hi;
		else if (v < {8'h00, lo})
			clamp8 = lo;
		else
			clamp8 = v[7:0];
	endfunction : clamp8

	////////////////////////////////////////////////////////////////////////////////
	swcdr_addr_t spi_addr;    // frame address
	logic        spi_wr;      // write strobe
	swcdr_byte_t spi_wdata;   // write data
	swcdr_byte_t rd_data;     // read mux

	// serial frame port
	swcdr_spi u_spi (
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.i_cs_n  (I_SPI_CS_N),
		.i_sclk  (I_SPI_SCLK),
		.i_mosi  (I_SPI_MOSI),
		.i_rdata (rd_data),
		.o_miso  (O_SPI_MISO),
		.o_addr  (spi_addr),
		.o_wr    (spi_wr),
		.o_wdata (spi_wdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	logic [1:0]  filt_q,  filt_d;   // filter time constant select
	logic        en_q,    en_d;     // recovery enable
	logic [1:0]  sel_q,   sel_d;    // recovery clock select
	swcdr_byte_t upper_q, upper_d;  // bit time upper limit
	swcdr_byte_t lower_q, lower_d;  // bit time lower limit

	// register writes; only rw bits are stored at all
	always_comb begin
		filt_d  = filt_q;
		en_d    = en_q;
		sel_d   = sel_q;
		upper_d = upper_q;
		lower_d = lower_q;
		if (spi_wr) begin
			unique case (spi_addr)
				`SWCDR_ADDR_CTRL1: begin
					filt_d = spi_wdata[`SWCDR_FILT_MSB:`SWCDR_FILT_LSB];
					en_d   = spi_wdata[`SWCDR_EN_BIT];
				end
				`SWCDR_ADDR_CTRL2: sel_d = spi_wdata[`SWCDR_SEL_MSB:`SWCDR_SEL_LSB];
				`SWCDR_ADDR_UPPER: upper_d = spi_wdata;
				`SWCDR_ADDR_LOWER: lower_d = spi_wdata;
				default: ;  // unmapped: ignored
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			filt_q  <= RST1[`SWCDR_FILT_MSB:`SWCDR_FILT_LSB];
			en_q    <= RST1[`SWCDR_EN_BIT];
			sel_q   <= RST2[`SWCDR_SEL_MSB:`SWCDR_SEL_LSB];
			upper_q <= `SWCDR_RST_UPPER;
			lower_q <= `SWCDR_RST_LOWER;
		end else begin
			filt_q  <= filt_d;
			en_q    <= en_d;
			sel_q   <= sel_d;
			upper_q <= upper_d;
			lower_q <= lower_d;
		end
	end

	always_comb begin
		rd_data = '0;
		unique case (spi_addr)
			`SWCDR_ADDR_CTRL1: begin
				rd_data[`SWCDR_FILT_MSB:`SWCDR_FILT_LSB] = filt_q;
				rd_data[`SWCDR_EN_BIT]                   = en_q;
			end
			`SWCDR_ADDR_CTRL2: rd_data[`SWCDR_SEL_MSB:`SWCDR_SEL_LSB] = sel_q;
			`SWCDR_ADDR_UPPER: rd_data = upper_q;
			`SWCDR_ADDR_LOWER: rd_data = lower_q;
			default: rd_data = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	logic [2:0]       div_q, div_d;    // free running prescaler
	logic             rxd_q, rxd_d;    // previous receive sample
	logic             seen_q, seen_d;  // first falling edge taken
	logic [CNT_W-1:0] cnt_q, cnt_d;    // ticks since last falling edge
	logic [15:0]      trk_q, trk_d;    // tracked bit time, 8.8 fixed
	logic             tick_w;          // recovery clock tick
	logic             fall_w;          // receive falling edge
	logic             upd_w;           // valid measurement this cycle
	swcdr_nbits_t     nbits_w;         // spacing in bits
	swcdr_shift_t     shift_w;         // selected filter shift
	logic [15:0]      per_bit_w;       // one bit of measured spacing
	swcdr_byte_t      sample_w;        // clamped bit time sample
	logic [16:0]      diff_w;          // sample minus tracked
	logic [16:0]      step_w;          // filtered step
	logic [15:0]      next_w;          // unclamped filter result

	// recovery datapath; the 25 MHz clock stands in for the fastest tick
	always_comb begin
		unique case (sel_q)
			`SWCDR_SEL_80M: tick_w = 1'b1;
			`SWCDR_SEL_40M: tick_w = div_q[0] == 1'b0;
			`SWCDR_SEL_20M: tick_w = div_q[1:0] == 2'h0;
			`SWCDR_SEL_10M: tick_w = div_q == 3'h0;
		endcase
		fall_w = rxd_q & ~I_RXD;
		// round spacing to whole bits against the tracked bit time
		nbits_w = 4'h1;
		for (int k = 2; k <= 11; k++) begin
			if ({3'h0, cnt_q, 1'b0} >= 20'((2 * k - 1) * trk_q[15:FW]))
				nbits_w = 4'(k);
		end
		upd_w = en_q && seen_q && fall_w && nbits_w >= `SWCDR_SPACE_MIN
			&& nbits_w <= `SWCDR_SPACE_MAX;
		per_bit_w = 16'(cnt_q / nbits_w);
		sample_w = clamp8(per_bit_w, lower_q, upper_q);
		unique case (filt_q)
			`SWCDR_FILT_8:  shift_w = `SWCDR_SHIFT_TC8;
			`SWCDR_FILT_16: shift_w = `SWCDR_SHIFT_TC16;
			`SWCDR_FILT_32: shift_w = `SWCDR_SHIFT_TC32;
			`SWCDR_FILT_ADAPT: begin
				if (nbits_w <= `SWCDR_SPACE_32_MAX)
					shift_w = `SWCDR_SHIFT_TC32;
				else if (nbits_w <= `SWCDR_SPACE_16_MAX)
					shift_w = `SWCDR_SHIFT_TC16;
				else
					shift_w = `SWCDR_SHIFT_TC8;
			end
		endcase
		diff_w = {1'b0, sample_w, 8'h00} - {1'b0, trk_q};
		step_w = 17'($signed(diff_w) >>> shift_w);
		next_w = trk_q + step_w[15:0];
		div_d  = div_q + 3'h1;
		rxd_d  = I_RXD;
		cnt_d  = cnt_q;
		seen_d = seen_q;
		trk_d  = trk_q;
		if (!en_q) begin
			cnt_d  = '0;
			seen_d = 1'b0;
			trk_d  = {I_NOMINAL_BIT_TIME, 8'h00};
		end else if (fall_w) begin
			cnt_d  = '0;
			seen_d = 1'b1;
			if (upd_w) begin
				if (clamp8({8'h00, next_w[15:FW]}, lower_q, upper_q) != next_w[15:FW])
					trk_d = {clamp8({8'h00, next_w[15:FW]}, lower_q, upper_q), 8'h00};
				else
					trk_d = next_w;
			end
		end else if (tick_w && cnt_q != '1) begin
			// saturate rather than wrap on a too fast clock
			cnt_d = cnt_q + 1'b1;
		end
	end

	// register the recovery state
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			div_q  <= '0;
			rxd_q  <= 1'b1;
			seen_q <= 1'b0;
			cnt_q  <= '0;
			trk_q  <= '0;
		end else begin
			div_q  <= div_d;
			rxd_q  <= rxd_d;
			seen_q <= seen_d;
			cnt_q  <= cnt_d;
			trk_q  <= trk_d;
		end
	end

	assign O_RECOVERY_ENABLE       = en_q;
	assign O_RECOVERY_CLOCK_SELECT = sel_q;
	assign O_BIT_TIME              = trk_q[15:FW];

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	a_reserved_read: assert property (
		spi_addr == `SWCDR_ADDR_CTRL1 |-> rd_data[7:4] == 4'h0 && rd_data[1] == 1'b0)
		else $error("reserved control bits read nonzero");
	a_fixed_const: assert property (
		filt_q != `SWCDR_FILT_ADAPT |-> shift_w == (filt_q == `SWCDR_FILT_8 ? `SWCDR_SHIFT_TC8 :
		filt_q == `SWCDR_FILT_16 ? `SWCDR_SHIFT_TC16 : `SWCDR_SHIFT_TC32))
		else $error("fixed filter constant wrong");
	a_adapt_short: assert property (
		filt_q == `SWCDR_FILT_ADAPT && upd_w && nbits_w <= `SWCDR_SPACE_32_MAX
		|-> shift_w == `SWCDR_SHIFT_TC32)
		else $error("adaptive constant wrong for short spacing");
	a_adapt_long: assert property (
		filt_q == `SWCDR_FILT_ADAPT && upd_w && nbits_w > `SWCDR_SPACE_16_MAX
		|-> shift_w == `SWCDR_SHIFT_TC8)
		else $error("adaptive constant wrong for long spacing");
	a_enable_off: assert property (
		!en_q |=> cnt_q == '0 && !seen_q && !upd_w)
		else $error("recovery runs while disabled");
	a_clock_slow: assert property (
		tick_w && sel_q == `SWCDR_SEL_10M ##1 sel_q == `SWCDR_SEL_10M |-> !tick_w)
		else $error("slowest recovery clock ticks too often");
	a_upper_clamp: assert property (
		upd_w && upper_q >= lower_q |=> O_BIT_TIME <= $past(upper_q))
		else $error("bit time above upper limit");
	a_lower_clamp: assert property (
		upd_w && upper_q >= lower_q |=> O_BIT_TIME >= $past(lower_q))
		else $error("bit time below lower limit");
	a_reset_ctrl1: assert property (
		$rose(I_RST_N) |-> filt_q == `SWCDR_FILT_16 && !en_q)
		else $error("control one reset value wrong");
	a_reset_clksel: assert property (
		$rose(I_RST_N) |-> sel_q == `SWCDR_SEL_80M)
		else $error("clock select reset value wrong");
	a_reset_limits: assert property (
		$rose(I_RST_N) |-> upper_q == `SWCDR_RST_UPPER && lower_q == `SWCDR_RST_LOWER)
		else $error("limit reset values wrong");
	a_frame_write: assert property (
		spi_wr && spi_addr == `SWCDR_ADDR_UPPER |=> upper_q == $past(spi_wdata))
		else $error("frame write not stored");
	a_track_hold: assert property (
		en_q && !upd_w |=> $stable(trk_q))
		else $error("tracked bit time moved without an edge");

endmodule : swcdr_top

/* File: swcdr_can_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// receive line of the bus: recessive high, one short dominant pulse per edge
module swcdr_can_model (
	input  wire logic i_clk,  // bench clock
	output logic      o_rxd   // receive line into the block
);
	// idle recessive, the line never floats
	initial o_rxd = 1'b1;

	// spacing counts from the previous falling edge, so call back to back
	task automatic falling(input int gap);
		repeat (gap - 3) @(posedge i_clk);
		o_rxd <= 1'b0;
		// short dominant pulse, well inside one nominal bit
		repeat (3) @(posedge i_clk);
		o_rxd <= 1'b1;
	endtask : falling
endmodule : swcdr_can_model

/* File: selective_wake_cdr_control_tb_top.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module selective_wake_cdr_control_tb_top
	import swcdr_pkg::*;
;
	logic        clk, rst_n, cs_n, sclk, mosi, rxd;  // driven inputs
	swcdr_byte_t nom;                                // nominal bit time
	logic        miso, en;                           // serial out, enable
	logic [1:0]  sel;                                // clock select out
	swcdr_byte_t bt, r, junk, rd_val;                // bit time, scratch
	swcdr_byte_t rq[$], bq[$], pq[$];                // expected notes
	int          errors, cmp_count, t_fx;            // counters, model
	event        rd_ev, bt_ev, pin_ev;               // result strobes
	// cases: filter code, edge gap, shift, clamped sample
	int c_code[7] = '{0, 1, 2, 3, 3, 3, 1};
	int c_gap[7]  = '{390, 390, 390, 390, 860, 1510, 290};
	int c_sh[7]   = '{3, 4, 5, 5, 4, 3, 4};
	int c_smp[7]  = '{164, 164, 164, 164, 164, 164, 152};

	swcdr_top u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_SPI_CS_N(cs_n), .I_SPI_SCLK(sclk),
		.I_SPI_MOSI(mosi), .O_SPI_MISO(miso), .I_RXD(rxd), .I_NOMINAL_BIT_TIME(nom),
		.O_RECOVERY_ENABLE(en), .O_RECOVERY_CLOCK_SELECT(sel), .O_BIT_TIME(bt));
	swcdr_can_model u_can (.i_clk(clk), .o_rxd(rxd));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input swcdr_byte_t e, input swcdr_byte_t g, input string m);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask : cmp

	// one compare per kind of result
	task automatic cmp_read(input swcdr_byte_t e, input swcdr_byte_t g);
		cmp(e, g, "read byte");
	endtask : cmp_read

	task automatic cmp_bt(input swcdr_byte_t e, input swcdr_byte_t g);
		cmp(e, g, "bit time");
	endtask : cmp_bt

	task automatic cmp_pin(input swcdr_byte_t e, input swcdr_byte_t g);
		cmp(e, g, "select and enable pins");
	endtask : cmp_pin

	// pins come from flops; look half a clock away from their launching edge
	task automatic note_pins(input logic [1:0] s, input logic e);
		pq.push_back({5'h00, s, e});
		@(negedge clk);
		->pin_ev;
	endtask : note_pins

	// one frame, lsb first; phases of four clocks keep clear of the sampler
	task automatic frame(input swcdr_addr_t a, input logic w, input swcdr_byte_t d,
		input int nb, output swcdr_byte_t q);
		logic [15:0] f;
		f = {d, w, a};
		q = 8'h00;
		@(posedge clk) cs_n <= 1'b0;
		for (int i = 0; i < nb; i++) begin
			@(posedge clk) sclk <= 1'b0;
			mosi <= f[i];
			repeat (3) @(posedge clk);
			// read bit is settled well before the next rise
			@(negedge clk) if (i >= 8) q[i-8] = miso;
			@(posedge clk) sclk <= 1'b1;
			repeat (3) @(posedge clk);
		end
		@(posedge clk) cs_n <= 1'b1;
		// covers the write commit latency and the gap between frames
		repeat (4) @(posedge clk);
	endtask : frame

	task automatic wr(input swcdr_addr_t a, input swcdr_byte_t d, input int nb = 16);
		frame(a, 1'b1, d, nb, junk);
	endtask : wr

	task automatic rd(input swcdr_addr_t a, input swcdr_byte_t e);
		rq.push_back(e);
		frame(a, 1'b0, 8'h00, 16, rd_val);
		->rd_ev;
	endtask : rd

	// fixed point tracker model, eight fraction bits
	task automatic edge_step(input int gap, input int sh, input int smp);
		u_can.falling(gap);
		t_fx = t_fx + (((smp << 8) - t_fx) >>> sh);
		bq.push_back(t_fx[15:8]);
		@(negedge clk);
		->bt_ev;
	endtask : edge_step

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////////
	// result watchers take the oldest note
	initial forever begin
		@(rd_ev);
		cmp_read(rq.pop_front(), rd_val);
	end
	initial forever begin
		@(bt_ev);
		cmp_bt(bq.pop_front(), bt);
	end
	initial forever begin
		@(pin_ev);
		cmp_pin(pq.pop_front(), {5'h00, sel, en});
	end

	// hang guard, about twice the expected run
	initial begin
		repeat (90000) @(posedge clk);
		errors++;
		report_and_stop();
	end

	initial begin
		rst_n = 1'b0;
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
		// recommended nominal for the fastest recovery clock
		nom = 8'hA0;
		void'($urandom(32'hD9A0));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd(7'h3C, 8'h04);
		rd(7'h3D, 8'h00);
		rd(7'h3E, 8'hA8);
		rd(7'h3F, 8'h98);
		note_pins(2'b00, 1'b0);
		$display("test reset values done");
		// random control byte, reserved bits must vanish
		r = 8'($urandom);
		wr(7'h3C, r);
		rd(7'h3C, {4'h0, r[3:2], 1'b0, r[0]});
		note_pins(2'b00, r[0]);
		for (int s = 0; s < 4; s++) begin
			wr(7'h3D, {6'h3F, 2'(s)});
			rd(7'h3D, {6'h00, 2'(s)});
			note_pins(2'(s), r[0]);
		end
		// 80 MHz suits the assumed rate, no overflow, fine enough
		wr(7'h3D, 8'h00);
		$display("test control fields done");
		// unmapped place and a short frame both leave no trace
		wr(7'h40, 8'($urandom));
		rd(7'h40, 8'h00);
		wr(7'h3C, ~r, 15);
		rd(7'h3C, {4'h0, r[3:2], 1'b0, r[0]});
		wr(7'h3E, 8'hA4);
		rd(7'h3E, 8'hA4);
		$display("test refusals done");
		// disabled tracker follows the nominal setting
		wr(7'h3C, 8'h04);
		@(posedge clk) nom <= 8'($urandom);
		repeat (4) @(posedge clk);
		bq.push_back(nom);
		@(negedge clk) ->bt_ev;
		@(posedge clk) nom <= 8'hA0;
		repeat (4) @(posedge clk);
		t_fx = 160 << 8;
		// long idle saturates the count, so the first edge of a case is dropped
		for (int k = 0; k < 7; k++) begin
			wr(7'h3C, {4'h0, 2'(c_code[k]), 2'b01});
			u_can.falling(4200);
			repeat (2) edge_step(c_gap[k], c_sh[k], c_smp[k]);
		end
		$display("test tracking done");
		// let the watchers take the last note before the verdict
		@(posedge clk);
		report_and_stop();
	end
endmodule : selective_wake_cdr_control_tb_top
